// *** include/icdio_pkg.sv ***
// package of register map, field layout and reset values for the isolated dio block
package icdio_pkg;
  // ****************************************************************
  // register byte offsets (one 32-bit word each)
  // ****************************************************************
  localparam logic [7:0] ADDR_IN_BANK0 = 8'h00;
  localparam logic [7:0] ADDR_IN_BANK1 = 8'h04;
  localparam logic [7:0] ADDR_MASK_BANK0 = 8'h08;
  localparam logic [7:0] ADDR_MASK_BANK1 = 8'h0c;
  localparam logic [7:0] ADDR_CAPT_BANK0 = 8'h10;
  localparam logic [7:0] ADDR_CAPT_BANK1 = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1c;
  localparam logic [7:0] ADDR_LL_DIR0 = 8'h20;
  localparam logic [7:0] ADDR_LL_DIR1 = 8'h24;
  localparam logic [7:0] ADDR_LL_OUT0 = 8'h28;
  localparam logic [7:0] ADDR_LL_OUT1 = 8'h2c;
  localparam logic [7:0] ADDR_LL_IN0 = 8'h30;
  localparam logic [7:0] ADDR_LL_IN1 = 8'h34;
  localparam logic [7:0] ADDR_ISO_OUT_LOW = 8'h38;
  localparam logic [7:0] ADDR_ISO_OUT_HIGH = 8'h3c;
  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int BANK0_BIT = 0;
  localparam int BANK1_BIT = 1;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [15:0] RESET_DIR = 16'h0000;
  localparam logic [1:0] RESET_FLAGS = 2'h0;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : icdio_pkg

// *** hdl/icdio_port.sv ***
// isolated input change detect, logic level lines and isolated outputs behind avalon-mm
// Contract
// RULE1: two isolated input banks, each readable as one 32-bit word.
// RULE2: per-bank 32-bit channel mask; 1 arms change detection, 0 disarms.
// RULE3: per-bank interrupt enable bit; 1 allows interrupt, 0 blocks it.
// RULE4: on a change, capture that bank's whole input word for later reading.
// RULE5: clearing a bank's interrupt request also clears its capture latch.
// RULE6: per-bit line direction, 0 input (reset), 1 output.
// RULE7: line direction settings read back, 0 input, 1 output.
// RULE8: two logic level banks of 16 lines; read returns line input state.
// RULE9: written 16-bit value drives the lines set as outputs.
// RULE10: 64 output switches; stored 1 turns switch on, 0 off.
// RULE11: 64-bit output written as low and high 32-bit halves.
// RULE12: the held 64-bit output value reads back with same encoding.
// RULE13: enabled channel change sets bank status; interrupt only if enabled.
module icdio_port
  import icdio_pkg::*;
#(
  parameter int IN_WIDTH = 32,
  parameter int LINE_WIDTH = 16
)
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic IRQ,
  input wire logic [IN_WIDTH-1:0] ISOLATED_INPUT0,
  input wire logic [IN_WIDTH-1:0] ISOLATED_INPUT1,
  input wire logic [LINE_WIDTH-1:0] LOGIC_LEVEL_IO0_IN,
  output logic [LINE_WIDTH-1:0] LOGIC_LEVEL_IO0_OUT,
  output logic [LINE_WIDTH-1:0] LOGIC_LEVEL_IO0_OE,
  input wire logic [LINE_WIDTH-1:0] LOGIC_LEVEL_IO1_IN,
  output logic [LINE_WIDTH-1:0] LOGIC_LEVEL_IO1_OUT,
  output logic [LINE_WIDTH-1:0] LOGIC_LEVEL_IO1_OE,
  output logic [63:0] OUTPUT_SWITCH
);

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  if (IN_WIDTH != 32)
  begin : g_bad_in
    $error("input bank width must be 32");
  end
  if (LINE_WIDTH < 1 || LINE_WIDTH > 32)
  begin : g_bad_line
    $error("line bank width must be 1 to 32");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  // byte-enable merge, used by the mask, line and switch registers; a lane left low keeps its old byte
  function automatic logic [31:0] merge_be(input logic [31:0] old_val,
                                           input logic [31:0] new_val,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  // one wait cycle: the request is taken on the edge where waitrequest is low,
  // so every access completes on the second edge of the request
  logic ack;
  logic wr_go;
  logic rd_go;
  assign wr_go = AVS_WRITE & ack;
  assign rd_go = AVS_READ & ack;

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      ack <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
    end
    else
    begin
      if ((AVS_READ | AVS_WRITE) & ~ack)
      begin
        ack <= 1'b1;
        AVS_WAITREQUEST <= 1'b0;
      end
      else
      begin
        ack <= 1'b0;
        AVS_WAITREQUEST <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // input sampling and change detection
  // ****************************************************************
  logic [31:0] in_q0;
  logic [31:0] in_q1;
  logic [31:0] mask0;
  logic [31:0] mask1;
  logic [31:0] capt0;
  logic [31:0] capt1;
  logic [1:0] irq_status;
  logic [1:0] irq_enable;
  logic [1:0] change;
  logic [1:0] clear_req;

  // previous sample is the reference; a masked-off channel never flags
  assign change[BANK0_BIT] = |((in_q0 ^ ISOLATED_INPUT0) & mask0); // RULE2 RULE13
  assign change[BANK1_BIT] = |((in_q1 ^ ISOLATED_INPUT1) & mask1); // RULE2 RULE13
  assign clear_req = (wr_go && AVS_ADDRESS == ADDR_IRQ_STATUS && AVS_BYTEENABLE[0]) ?
                     AVS_WRITEDATA[1:0] : 2'h0;

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      in_q0 <= RESET_WORD;
      in_q1 <= RESET_WORD;
    end
    else
    begin
      in_q0 <= ISOLATED_INPUT0; // RULE1
      in_q1 <= ISOLATED_INPUT1; // RULE1
    end
  end

  // status is sticky; a new change in the clearing cycle wins over the clear
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      irq_status <= RESET_FLAGS;
    end
    else
    begin
      irq_status <= (irq_status & ~clear_req) | change; // RULE13
    end
  end

  // the capture holds the word of the first change until software clears it
  // a change in the clearing cycle starts a fresh capture, so no event goes unseen
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      capt0 <= RESET_WORD;
      capt1 <= RESET_WORD;
    end
    else
    begin
      if (change[BANK0_BIT] && (!irq_status[BANK0_BIT] || clear_req[BANK0_BIT]))
      begin
        capt0 <= ISOLATED_INPUT0; // RULE4
      end
      else if (clear_req[BANK0_BIT])
      begin
        capt0 <= RESET_WORD; // RULE5
      end
      if (change[BANK1_BIT] && (!irq_status[BANK1_BIT] || clear_req[BANK1_BIT]))
      begin
        capt1 <= ISOLATED_INPUT1; // RULE4
      end
      else if (clear_req[BANK1_BIT])
      begin
        capt1 <= RESET_WORD; // RULE5
      end
    end
  end

  // ****************************************************************
  // interrupt line
  // ****************************************************************
  // clear and new change are folded in so the line never lags the status by a cycle
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      IRQ <= 1'b0;
    end
    else
    begin
      IRQ <= |(((irq_status & ~clear_req) | change) & irq_enable); // RULE3 RULE13
    end
  end

  // ****************************************************************
  // software writable registers
  // ****************************************************************
  logic [15:0] dir0;
  logic [15:0] dir1;
  logic [15:0] lout0;
  logic [15:0] lout1;

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      mask0 <= RESET_WORD;
      mask1 <= RESET_WORD;
      irq_enable <= RESET_FLAGS;
    end
    else if (wr_go)
    begin
      if (AVS_ADDRESS == ADDR_MASK_BANK0)
      begin
        mask0 <= merge_be(mask0, AVS_WRITEDATA, AVS_BYTEENABLE); // RULE2
      end
      if (AVS_ADDRESS == ADDR_MASK_BANK1)
      begin
        mask1 <= merge_be(mask1, AVS_WRITEDATA, AVS_BYTEENABLE); // RULE2
      end
      if (AVS_ADDRESS == ADDR_IRQ_ENABLE && AVS_BYTEENABLE[0])
      begin
        irq_enable <= AVS_WRITEDATA[1:0]; // RULE3
      end
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      dir0 <= RESET_DIR; // RULE6
      dir1 <= RESET_DIR; // RULE6
      lout0 <= RESET_DIR;
      lout1 <= RESET_DIR;
    end
    else if (wr_go)
    begin
      if (AVS_ADDRESS == ADDR_LL_DIR0)
      begin
        dir0 <= 16'(merge_be({16'h0000, dir0}, AVS_WRITEDATA, AVS_BYTEENABLE)); // RULE6
      end
      if (AVS_ADDRESS == ADDR_LL_DIR1)
      begin
        dir1 <= 16'(merge_be({16'h0000, dir1}, AVS_WRITEDATA, AVS_BYTEENABLE)); // RULE6
      end
      if (AVS_ADDRESS == ADDR_LL_OUT0)
      begin
        lout0 <= 16'(merge_be({16'h0000, lout0}, AVS_WRITEDATA, AVS_BYTEENABLE)); // RULE9
      end
      if (AVS_ADDRESS == ADDR_LL_OUT1)
      begin
        lout1 <= 16'(merge_be({16'h0000, lout1}, AVS_WRITEDATA, AVS_BYTEENABLE)); // RULE9
      end
    end
  end

  // output value sits on the pin only where the direction is output
  // a line set as input is never driven, whatever its output register holds
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      LOGIC_LEVEL_IO0_OUT <= '0;
      LOGIC_LEVEL_IO0_OE <= '0;
      LOGIC_LEVEL_IO1_OUT <= '0;
      LOGIC_LEVEL_IO1_OE <= '0;
    end
    else
    begin
      LOGIC_LEVEL_IO0_OUT <= LINE_WIDTH'(lout0 & dir0); // RULE9
      LOGIC_LEVEL_IO0_OE <= LINE_WIDTH'(dir0); // RULE6
      LOGIC_LEVEL_IO1_OUT <= LINE_WIDTH'(lout1 & dir1); // RULE9
      LOGIC_LEVEL_IO1_OE <= LINE_WIDTH'(dir1); // RULE6
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      OUTPUT_SWITCH <= {RESET_WORD, RESET_WORD};
    end
    else if (wr_go)
    begin
      if (AVS_ADDRESS == ADDR_ISO_OUT_LOW)
      begin
        OUTPUT_SWITCH[31:0] <= merge_be(OUTPUT_SWITCH[31:0], AVS_WRITEDATA,
                                        AVS_BYTEENABLE); // RULE10 RULE11
      end
      if (AVS_ADDRESS == ADDR_ISO_OUT_HIGH)
      begin
        OUTPUT_SWITCH[63:32] <= merge_be(OUTPUT_SWITCH[63:32], AVS_WRITEDATA,
                                         AVS_BYTEENABLE); // RULE10 RULE11
      end
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // input banks and lines read the live pins in the wait cycle
  // status and enable share one layout: bit 0 bank 0, bit 1 bank 1
  logic [31:0] next_readdata;

  always_comb
  begin
    unique case (AVS_ADDRESS)
      ADDR_IN_BANK0: next_readdata = ISOLATED_INPUT0; // RULE1
      ADDR_IN_BANK1: next_readdata = ISOLATED_INPUT1; // RULE1
      ADDR_MASK_BANK0: next_readdata = mask0;
      ADDR_MASK_BANK1: next_readdata = mask1;
      ADDR_CAPT_BANK0: next_readdata = capt0; // RULE4
      ADDR_CAPT_BANK1: next_readdata = capt1; // RULE4
      ADDR_IRQ_STATUS: next_readdata = {30'h0, irq_status};
      ADDR_IRQ_ENABLE: next_readdata = {30'h0, irq_enable};
      ADDR_LL_DIR0: next_readdata = {16'h0000, dir0}; // RULE7
      ADDR_LL_DIR1: next_readdata = {16'h0000, dir1}; // RULE7
      ADDR_LL_OUT0: next_readdata = {16'h0000, lout0};
      ADDR_LL_OUT1: next_readdata = {16'h0000, lout1};
      ADDR_LL_IN0: next_readdata = 32'(LOGIC_LEVEL_IO0_IN); // RULE8
      ADDR_LL_IN1: next_readdata = 32'(LOGIC_LEVEL_IO1_IN); // RULE8
      ADDR_ISO_OUT_LOW: next_readdata = OUTPUT_SWITCH[31:0]; // RULE12
      ADDR_ISO_OUT_HIGH: next_readdata = OUTPUT_SWITCH[63:32]; // RULE12
      default: next_readdata = UNMAPPED_READ;
    endcase
  end

  // data is loaded in the wait cycle so it stands at the accepting edge
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      AVS_READDATA <= RESET_WORD;
    end
    else if (AVS_READ & ~ack)
    begin
      AVS_READDATA <= next_readdata;
    end
  end

endmodule // icdio_port

// *** sim/icdio_checker.sv ***
// assertions on the register bus, lines and switches of the isolated dio block
module icdio_checker
  import icdio_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic IRQ,
  input wire logic [31:0] ISOLATED_INPUT0,
  input wire logic [15:0] LOGIC_LEVEL_IO0_IN,
  input wire logic [15:0] LOGIC_LEVEL_IO0_OUT,
  input wire logic [15:0] LOGIC_LEVEL_IO0_OE,
  input wire logic [63:0] OUTPUT_SWITCH
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // accepted transfers; partial lane writes are left out on purpose
  // ****
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE == 4'hf;
  assign rd_ok = AVS_READ && !AVS_WAITREQUEST;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);
  reset_quiet_a: assert property (disable iff (1'b0)
    SYS_RST |=> !IRQ && OUTPUT_SWITCH == '0 && LOGIC_LEVEL_IO0_OE == '0)
    else $error("outputs not quiet after reset");
  dir_oe_a: assert property (
    wr_ok && AVS_ADDRESS == ADDR_LL_DIR0 |-> ##2
    LOGIC_LEVEL_IO0_OE == $past(AVS_WRITEDATA[15:0], 2))
    else $error("direction not applied");
  out_drive_a: assert property (
    wr_ok && AVS_ADDRESS == ADDR_LL_OUT0 |-> ##2
    LOGIC_LEVEL_IO0_OUT == ($past(AVS_WRITEDATA[15:0], 2) & LOGIC_LEVEL_IO0_OE))
    else $error("line value not driven");
  sw_low_a: assert property (
    wr_ok && AVS_ADDRESS == ADDR_ISO_OUT_LOW |-> ##2
    OUTPUT_SWITCH[31:0] == $past(AVS_WRITEDATA, 2))
    else $error("low switch half wrong");
  sw_high_a: assert property (
    wr_ok && AVS_ADDRESS == ADDR_ISO_OUT_HIGH |-> ##2
    OUTPUT_SWITCH[63:32] == $past(AVS_WRITEDATA, 2))
    else $error("high switch half wrong");
  rb_low_a: assert property (
    rd_ok && AVS_ADDRESS == ADDR_ISO_OUT_LOW |-> AVS_READDATA == OUTPUT_SWITCH[31:0])
    else $error("switch readback wrong");
  dir_rb_a: assert property (
    rd_ok && AVS_ADDRESS == ADDR_LL_DIR0 |-> AVS_READDATA[15:0] == LOGIC_LEVEL_IO0_OE)
    else $error("direction readback wrong");
  in_read_a: assert property (
    rd_ok && AVS_ADDRESS == ADDR_IN_BANK0 |-> AVS_READDATA == $past(ISOLATED_INPUT0))
    else $error("input word read wrong");
  line_read_a: assert property (
    rd_ok && AVS_ADDRESS == ADDR_LL_IN0 |-> AVS_READDATA[15:0] == $past(LOGIC_LEVEL_IO0_IN))
    else $error("line state read wrong");
  cover property ($rose(IRQ));
  cover property (wr_ok && AVS_ADDRESS == ADDR_ISO_OUT_HIGH);
  cover property (rd_ok && AVS_ADDRESS == ADDR_CAPT_BANK0);
endmodule // icdio_checker

bind icdio_port icdio_checker icdio_checker_inst (.*);

// *** sim/icdio_field.sv ***
// field wiring model of the logic level lines
module icdio_field (
  input wire logic [15:0] LOGIC_LEVEL_IO0_OUT,
  input wire logic [15:0] LOGIC_LEVEL_IO0_OE,
  input wire logic [15:0] LOGIC_LEVEL_IO1_OUT,
  input wire logic [15:0] LOGIC_LEVEL_IO1_OE,
  input wire logic [15:0] ext0,
  input wire logic [15:0] ext1,
  output logic [15:0] LOGIC_LEVEL_IO0_IN,
  output logic [15:0] LOGIC_LEVEL_IO1_IN
);
  timeunit 1ns;
  timeprecision 1ps;
  // a line the port does not drive shows the outside driver's level
  assign LOGIC_LEVEL_IO0_IN = (LOGIC_LEVEL_IO0_OUT & LOGIC_LEVEL_IO0_OE)
                              | (ext0 & ~LOGIC_LEVEL_IO0_OE);
  assign LOGIC_LEVEL_IO1_IN = (LOGIC_LEVEL_IO1_OUT & LOGIC_LEVEL_IO1_OE)
                              | (ext1 & ~LOGIC_LEVEL_IO1_OE);
endmodule // icdio_field

// *** sim/icdio_port_tb.sv ***
// self-checking testbench of the isolated dio block
module icdio_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import icdio_pkg::*;
  logic CLOCK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [7:0] AVS_ADDRESS = 8'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0] AVS_BYTEENABLE = 4'hf;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic IRQ;
  logic [31:0] ISOLATED_INPUT0 = 32'h0;
  logic [31:0] ISOLATED_INPUT1 = 32'h0;
  logic [15:0] LOGIC_LEVEL_IO0_IN, LOGIC_LEVEL_IO0_OUT, LOGIC_LEVEL_IO0_OE;
  logic [15:0] LOGIC_LEVEL_IO1_IN, LOGIC_LEVEL_IO1_OUT, LOGIC_LEVEL_IO1_OE;
  logic [63:0] OUTPUT_SWITCH;
  logic [15:0] ext0 = 16'h3c3c;
  logic [15:0] ext1 = 16'hc3c3;
  logic [31:0] rd;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  icdio_port icdio_port_inst (.*);
  icdio_field icdio_field_inst (.*);
  initial
  begin
    forever #2.5 CLOCK = ~CLOCK;
  end
  // ****
  // shared tasks
  // ****
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one transfer, held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_READ <= !wr;
    AVS_WRITE <= wr;
    do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  task automatic print_verdict;
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    bus(1'b0, ADDR_LL_DIR1, 32'h0);
    chk("dir1 reset", rd, RESET_DIR);
    bus(1'b1, 8'h40, 32'hffff_ffff);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd, UNMAPPED_READ);
  endtask
  task automatic t_iso;
    bus(1'b1, ADDR_ISO_OUT_LOW, 32'h8000_0001);
    bus(1'b1, ADDR_ISO_OUT_HIGH, 32'h1234_abcd);
    repeat (2) @(posedge CLOCK);
    chk("switches", OUTPUT_SWITCH, 64'h1234_abcd_8000_0001);
    bus(1'b0, ADDR_ISO_OUT_HIGH, 32'h0);
    chk("high readback", rd, 32'h1234_abcd);
    bus(1'b0, ADDR_ISO_OUT_LOW, 32'h0);
    chk("low readback", rd, 32'h8000_0001);
  endtask
  task automatic t_line;
    logic [15:0] e;
    for (int b = 0; b < 2; b++)
    begin
      e = b ? ext1 : ext0;
      bus(1'b1, ADDR_LL_DIR0 + 8'(4 * b), 32'h0000_0ff0);
      bus(1'b1, ADDR_LL_OUT0 + 8'(4 * b), 32'h0000_a5a5);
      bus(1'b0, ADDR_LL_DIR0 + 8'(4 * b), 32'h0);
      chk("dir readback", rd[15:0], 16'h0ff0);
      chk("enables", b ? LOGIC_LEVEL_IO1_OE : LOGIC_LEVEL_IO0_OE, 16'h0ff0);
      bus(1'b0, ADDR_LL_IN0 + 8'(4 * b), 32'h0);
      chk("line state", rd[15:0], 16'h05a0 | (e & 16'hf00f));
    end
  endtask
  task automatic t_detect;
    bus(1'b1, ADDR_MASK_BANK0, 32'h0000_0008);
    bus(1'b1, ADDR_MASK_BANK1, 32'h0000_0001);
    bus(1'b1, ADDR_IRQ_ENABLE, 32'h1);
    ISOLATED_INPUT0 <= 32'h0000_0004;
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
    chk("unarmed status", rd, 32'h0);
    ISOLATED_INPUT0 <= 32'h0000_000c;
    ISOLATED_INPUT1 <= 32'h0000_0001;
    repeat (3) @(posedge CLOCK);
    chk("irq raised", IRQ, 1'b1);
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
    chk("status", rd, 32'h3);
    bus(1'b0, ADDR_IN_BANK0, 32'h0);
    chk("input word0", rd, 32'h0000_000c);
    ISOLATED_INPUT0 <= 32'h0;
    bus(1'b0, ADDR_IN_BANK1, 32'h0);
    chk("input word", rd, 32'h1);
    bus(1'b0, ADDR_CAPT_BANK0, 32'h0);
    chk("capture0", rd, 32'h0000_000c);
    bus(1'b1, ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge CLOCK);
    chk("irq blocked", IRQ, 1'b0);
    bus(1'b0, ADDR_CAPT_BANK0, 32'h0);
    chk("capture0 cleared", rd, 32'h0);
    bus(1'b0, ADDR_CAPT_BANK1, 32'h0);
    chk("capture1 held", rd, 32'h1);
  endtask
  always @(posedge CLOCK)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (3) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    t_reset;
    t_iso;
    t_line;
    t_detect;
    print_verdict;
  end
endmodule // icdio_port_tb
